// >>> design/reader_interrupt_request_unit.sv
// Interrupt flags, enables and request pin with an AHB-Lite register port
//
// Notes on behaviour
// - Primary flag write: bit 7 high sets, low clears each bit written 1.
// - Secondary flag write: bit 7 selects set or clear for bits 6..0, bit 6 being the combined flag.
// - Upper level flag latches while live upper status is high.
// - Lower level flag latches while live lower status is high.
// - Command finished flag sets when a command ends by itself.
// - Unknown command start forces idle and sets command finished flag.
// - Host starting the idle command does not set command finished.
// - Transmit done flag sets right after the last transmitted bit.
// - Receive end flag sets at stream end, errors or not.
// - Error flag sets when any of five fault indications becomes set.
// - Frame start flag sets on start of frame or subcarrier detection.
// - Combined flag sets whenever any enabled flag is active.
// - Card detect flag sets when low power detection finds a card.
// - One underflow flag per timer, bits 4..0 for timers 4..0.
// - Primary enable bits 6..0 gate primary flags into combined flag.
// - Primary enable bit 7 inverts the request pin level.
// - Primary flag register is all zeros after reset.
// - Secondary enable bits 5..0 gate card and timer flags.
// - Secondary enable bit 6 lets the combined flag reach the pin.
// - Secondary enable bit 7 picks push-pull, else open-drain drive.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
module reader_interrupt_request_unit (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Event sources, same clock domain
  input  wire logic        upper_level_live_status,
  input  wire logic        lower_level_live_status,
  input  wire logic        command_self_end,
  input  wire logic        command_unknown_start,
  input  wire logic        command_host_idle_start,
  input  wire logic        transmit_last_bit_sent,
  input  wire logic        receive_stream_end,
  input  wire logic        buffer_write_fault,
  input  wire logic        buffer_overflow_fault,
  input  wire logic        protocol_fault,
  input  wire logic        empty_send_fault,
  input  wire logic        integrity_fault,
  input  wire logic        frame_start_detect,
  input  wire logic        card_detect_event,
  input  wire logic [4:0]  timer_underflow,
  // Command field return to idle
  output logic             command_force_idle,
  // Request pin
  output logic             request_pin_out,
  output logic             request_pin_oe,
  output logic             request_level
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [6:0]  primary_flags_reg;
  logic [6:0]  primary_flags_next;
  logic [5:0]  secondary_flags_reg;
  logic [5:0]  secondary_flags_next;
  logic        combined_request_flag_reg;
  logic        combined_request_flag_next;
  logic [7:0]  event_enables_primary_reg;
  logic [7:0]  event_enables_secondary_reg;
  logic [4:0]  fault_prev_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_idx_reg;
  logic [31:0] hrdata_reg;
  logic        hreadyout_reg;
  logic        force_idle_reg;
  logic        pin_out_reg;
  logic        pin_oe_reg;
  logic        level_reg;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire logic       addr_phase;
  wire logic       rd_take;
  wire logic       wr_take;
  wire logic [7:0] addr_idx;
  wire logic       idx_prim_flags;
  wire logic       idx_sec_flags;
  wire logic       idx_prim_en;
  wire logic       idx_sec_en;
  wire logic [31:0] read_value;

  assign addr_phase = hsel && hready && htrans[1];
  assign rd_take    = addr_phase && !hwrite;
  assign wr_take    = addr_phase && hwrite;
  assign addr_idx   = (haddr[31:10] == 22'h00_0000 &&
                       haddr[1:0] == 2'b00) ?
                      haddr[9:2] : 8'hff;

  assign idx_prim_flags = addr_idx == irq_unit_pkg::IDX_EVENT_FLAGS_PRIMARY;
  assign idx_sec_flags  = addr_idx == irq_unit_pkg::IDX_EVENT_FLAGS_SECONDARY;
  assign idx_prim_en    = addr_idx == irq_unit_pkg::IDX_EVENT_ENABLES_PRIMARY;
  assign idx_sec_en     =
    addr_idx == irq_unit_pkg::IDX_EVENT_ENABLES_SECONDARY;

  wire logic [31:0] prim_flags_word;
  wire logic [31:0] sec_flags_word;
  wire logic [31:0] prim_en_word;
  wire logic [31:0] sec_en_word;

  assign prim_flags_word = {25'h000_0000, primary_flags_reg};
  assign sec_flags_word  = {25'h000_0000, combined_request_flag_reg,
                            secondary_flags_reg};
  assign prim_en_word    = {24'h00_0000, event_enables_primary_reg};
  assign sec_en_word     = {24'h00_0000, event_enables_secondary_reg};
  // Unmapped or unaligned reads give zero
  assign read_value =
    idx_prim_flags ? prim_flags_word :
    idx_sec_flags  ? sec_flags_word  :
    idx_prim_en    ? prim_en_word    :
    idx_sec_en     ? sec_en_word     :
                     32'h0000_0000;

  // ---------------------------------------------------------------
  // Write data phase decode
  // ---------------------------------------------------------------
  wire logic       wr_prim_flags;
  wire logic       wr_sec_flags;
  wire logic       wr_prim_en;
  wire logic       wr_sec_en;
  wire logic       wr_set_mode;
  wire logic [6:0] sw_prim_set;
  wire logic [6:0] sw_prim_clr;
  wire logic [6:0] sw_sec_set;
  wire logic [6:0] sw_sec_clr;

  assign wr_prim_flags = wr_pend_reg &&
    wr_idx_reg == irq_unit_pkg::IDX_EVENT_FLAGS_PRIMARY;
  assign wr_sec_flags  = wr_pend_reg &&
    wr_idx_reg == irq_unit_pkg::IDX_EVENT_FLAGS_SECONDARY;
  assign wr_prim_en    = wr_pend_reg &&
    wr_idx_reg == irq_unit_pkg::IDX_EVENT_ENABLES_PRIMARY;
  assign wr_sec_en     = wr_pend_reg &&
    wr_idx_reg == irq_unit_pkg::IDX_EVENT_ENABLES_SECONDARY;
  assign wr_set_mode   = hwdata[irq_unit_pkg::SET_MODE_BIT];

  assign sw_prim_set = (wr_prim_flags && wr_set_mode) ?
                       hwdata[6:0] : 7'h00;
  assign sw_prim_clr = (wr_prim_flags && !wr_set_mode) ?
                       hwdata[6:0] : 7'h00;
  assign sw_sec_set  = (wr_sec_flags && wr_set_mode) ?
                       hwdata[6:0] : 7'h00;
  assign sw_sec_clr  = (wr_sec_flags && !wr_set_mode) ?
                       hwdata[6:0] : 7'h00;

  // ---------------------------------------------------------------
  // Hardware events
  // ---------------------------------------------------------------
  wire logic [4:0] fault_now;
  wire logic [4:0] fault_rise;
  wire logic [6:0] hw_prim_set;
  wire logic [5:0] hw_sec_set;
  wire logic [6:0] prim_enabled;
  wire logic [5:0] sec_enabled;
  wire logic       any_enabled;

  assign fault_now = {buffer_write_fault, buffer_overflow_fault,
                      protocol_fault, empty_send_fault, integrity_fault};

  genvar g;
  generate
    for (g = 0; g < irq_unit_pkg::FAULT_W; g++) begin : g_fault
      assign fault_rise[g] = fault_now[g] && !fault_prev_reg[g];
    end
  endgenerate

  assign hw_prim_set[irq_unit_pkg::UPPER_LEVEL_BIT] =
    upper_level_live_status;
  assign hw_prim_set[irq_unit_pkg::LOWER_LEVEL_BIT] =
    lower_level_live_status;
  assign hw_prim_set[irq_unit_pkg::COMMAND_DONE_BIT] =
    command_self_end || command_unknown_start;
  assign hw_prim_set[irq_unit_pkg::TRANSMIT_DONE_BIT] =
    transmit_last_bit_sent;
  assign hw_prim_set[irq_unit_pkg::RECEIVE_END_BIT] = receive_stream_end;
  assign hw_prim_set[irq_unit_pkg::ERROR_EVENT_BIT] = |fault_rise;
  assign hw_prim_set[irq_unit_pkg::FRAME_START_BIT] = frame_start_detect;

  assign hw_sec_set = {card_detect_event, timer_underflow};

  assign prim_enabled = primary_flags_reg & event_enables_primary_reg[6:0];
  assign sec_enabled  = secondary_flags_reg &
                        event_enables_secondary_reg[5:0];
  // Feeds the combined flag one edge later
  assign any_enabled  = (|prim_enabled) || (|sec_enabled);

  // ---------------------------------------------------------------
  // Flag next values, hardware set wins over clear
  // ---------------------------------------------------------------
  // Primary bits, a hardware event beats a software clear
  genvar p;
  generate
    for (p = 0; p < irq_unit_pkg::PRIMARY_FLAG_W; p++) begin : g_prim
      assign primary_flags_next[p] = hw_prim_set[p] || sw_prim_set[p] ||
        (primary_flags_reg[p] && !sw_prim_clr[p]);
    end
  endgenerate

  // Secondary bits, same priority
  genvar s;
  generate
    for (s = 0; s < irq_unit_pkg::SECONDARY_FLAG_W; s++) begin : g_sec
      assign secondary_flags_next[s] = hw_sec_set[s] || sw_sec_set[s] ||
        (secondary_flags_reg[s] && !sw_sec_clr[s]);
    end
  endgenerate

  assign combined_request_flag_next =
    (combined_request_flag_reg && !sw_sec_clr[irq_unit_pkg::COMBINED_BIT])
    || sw_sec_set[irq_unit_pkg::COMBINED_BIT] || any_enabled;

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  wire logic pin_level_next;
  wire logic push_pull;

  assign pin_level_next =
    (combined_request_flag_reg &&
     event_enables_secondary_reg[irq_unit_pkg::PIN_GATE_BIT]) ^
    event_enables_primary_reg[irq_unit_pkg::PIN_INVERT_BIT];
  assign push_pull =
    event_enables_secondary_reg[irq_unit_pkg::PIN_DRIVER_BIT];

  // ---------------------------------------------------------------
  // Flag registers
  // ---------------------------------------------------------------
  // zero after reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      primary_flags_reg         <= irq_unit_pkg::PRIMARY_FLAGS_RESET;
      secondary_flags_reg       <= irq_unit_pkg::SECONDARY_FLAGS_RESET;
      combined_request_flag_reg <= irq_unit_pkg::COMBINED_RESET;
      fault_prev_reg            <= irq_unit_pkg::FAULT_RESET;
    end else begin
      primary_flags_reg         <= primary_flags_next;
      secondary_flags_reg       <= secondary_flags_next;
      combined_request_flag_reg <= combined_request_flag_next;
      fault_prev_reg            <= fault_now;
    end
  end

  // ---------------------------------------------------------------
  // Enable registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      event_enables_primary_reg   <= irq_unit_pkg::ENABLES_RESET;
      event_enables_secondary_reg <= irq_unit_pkg::ENABLES_RESET;
    end else begin
      if (wr_prim_en) begin
        event_enables_primary_reg <= hwdata[7:0];
      end
      if (wr_sec_en) begin
        event_enables_secondary_reg <= hwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus phase registers
  // ---------------------------------------------------------------
  // Write held over to its data phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'hff;
    end else begin
      wr_pend_reg <= wr_take;
      wr_idx_reg  <= addr_idx;
    end
  end

  // Read word captured in the address phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hrdata_reg <= irq_unit_pkg::RDATA_RESET;
    end else if (rd_take) begin
      hrdata_reg <= read_value;
    end
  end

  // Zero wait states
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hreadyout_reg <= 1'b1;
    end else begin
      hreadyout_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  // driver select
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_out_reg <= 1'b0;
    end else begin
      pin_out_reg <= push_pull ? pin_level_next : 1'b0;
    end
  end

  // open-drain release, pin held low through reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_oe_reg <= 1'b1;
    end else begin
      pin_oe_reg <= push_pull ? 1'b1 : !pin_level_next;
    end
  end

  // Logical level, before the driver choice
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= pin_level_next;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      force_idle_reg <= 1'b0;
    end else begin
      force_idle_reg <= command_unknown_start;
    end
  end

  assign hreadyout          = hreadyout_reg;
  assign hresp              = irq_unit_pkg::HRESP_OKAY;
  assign hrdata             = hrdata_reg;
  assign command_force_idle = force_idle_reg;
  assign request_pin_out    = pin_out_reg;
  assign request_pin_oe     = pin_oe_reg;
  assign request_level      = level_reg;

endmodule

// >>> design/irq_unit_pkg.sv
// Constants for the reader interrupt request unit
package irq_unit_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_EVENT_FLAGS_PRIMARY     = 8'h06;
  localparam logic [7:0] IDX_EVENT_FLAGS_SECONDARY   = 8'h07;
  localparam logic [7:0] IDX_EVENT_ENABLES_PRIMARY   = 8'h08;
  localparam logic [7:0] IDX_EVENT_ENABLES_SECONDARY = 8'h09;
  localparam int         ADDR_LSB                    = 2;
  localparam int         ADDR_IDX_W                  = 8;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SET_MODE_BIT        = 7;
  localparam int PRIMARY_FLAG_W      = 7;
  localparam int SECONDARY_FLAG_W    = 6;
  localparam int FAULT_W             = 5;
  localparam int TIMER_W             = 5;
  localparam int UPPER_LEVEL_BIT     = 6;
  localparam int LOWER_LEVEL_BIT     = 5;
  localparam int COMMAND_DONE_BIT    = 4;
  localparam int TRANSMIT_DONE_BIT   = 3;
  localparam int RECEIVE_END_BIT     = 2;
  localparam int ERROR_EVENT_BIT     = 1;
  localparam int FRAME_START_BIT     = 0;
  localparam int COMBINED_BIT        = 6;
  localparam int CARD_DETECT_BIT     = 5;
  localparam int PIN_INVERT_BIT      = 7;
  localparam int PIN_GATE_BIT        = 6;
  localparam int PIN_DRIVER_BIT      = 7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] PRIMARY_FLAGS_RESET   = 7'h00;
  localparam logic [5:0] SECONDARY_FLAGS_RESET = 6'h00;
  localparam logic       COMBINED_RESET        = 1'b0;
  localparam logic [7:0] ENABLES_RESET         = 8'h00;
  localparam logic [4:0] FAULT_RESET           = 5'h00;
  localparam logic [31:0] RDATA_RESET          = 32'h0000_0000;

  // ---------------------------------------------------------------
  // AHB encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;
  localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// >>> dv/host_pin_model.sv
// Host side of the request pin, with its pull-up
`timescale 1ns/100ps
module host_pin_model (
  input  wire logic request_pin_out,
  input  wire logic request_pin_oe,
  output logic      pin_seen
);
  // ------------------------------------------------------------
  // Wire level
  // ------------------------------------------------------------
  // pull-up when released
  assign pin_seen = request_pin_oe ? request_pin_out : 1'b1;
endmodule

// >>> dv/irq_unit_asserts.sv
// Port checker for the interrupt request unit
`timescale 1ns/100ps
module reader_irq_checker (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        upper_level_live_status,
  input wire logic        command_unknown_start,
  input wire logic        command_host_idle_start,
  input wire logic        transmit_last_bit_sent,
  input wire logic        card_detect_event,
  input wire logic        command_force_idle,
  input wire logic        request_pin_out,
  input wire logic        request_pin_oe,
  input wire logic        request_level
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire rd_go  = hsel && hready && htrans[1] && !hwrite;
  wire rd_pri = rd_go && haddr == 32'h0000_0018;
  wire rd_sec = rd_go && haddr == 32'h0000_001c;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  upper_latch_a: assert property (
    upper_level_live_status ##1 rd_pri |=> hrdata[6])
    else $error("upper level flag not latched");
  tx_latch_a: assert property (
    transmit_last_bit_sent ##1 rd_pri |=> hrdata[3])
    else $error("transmit done flag not latched");
  card_latch_a: assert property (
    card_detect_event ##1 rd_sec |=> hrdata[5])
    else $error("card detect flag not latched");
  force_idle_a: assert property (
    command_unknown_start |=> command_force_idle)
    else $error("unknown command not forced idle");
  host_idle_a: assert property (
    command_host_idle_start && !command_unknown_start
    |=> !command_force_idle)
    else $error("host idle start forced idle");
  open_drain_a: assert property (
    !request_pin_oe |-> !request_pin_out && request_level)
    else $error("released pin with wrong level");
  push_pull_a: assert property (
    request_pin_out |-> request_pin_oe && request_level)
    else $error("pin driven high wrongly");
  mode_bit_zero_a: assert property (
    rd_pri || rd_sec |=> hrdata[31:7] == 25'h0)
    else $error("flag read shows mode bit");
  cover property (rd_pri ##1 hrdata[6]);
  cover property (request_pin_out);
  cover property (!request_pin_oe);
endmodule
bind reader_interrupt_request_unit reader_irq_checker u_chk (
  .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .upper_level_live_status(upper_level_live_status),
  .command_unknown_start(command_unknown_start),
  .command_host_idle_start(command_host_idle_start),
  .transmit_last_bit_sent(transmit_last_bit_sent),
  .card_detect_event(card_detect_event),
  .command_force_idle(command_force_idle),
  .request_pin_out(request_pin_out), .request_pin_oe(request_pin_oe),
  .request_level(request_level));

// >>> dv/reader_interrupt_request_unit_test.sv
// Self-checking bench for the interrupt request unit
`timescale 1ns/100ps
module reader_interrupt_request_unit_test;
  localparam logic [7:0] PF = irq_unit_pkg::IDX_EVENT_FLAGS_PRIMARY;
  localparam logic [7:0] SF = irq_unit_pkg::IDX_EVENT_FLAGS_SECONDARY;
  localparam logic [7:0] PE = irq_unit_pkg::IDX_EVENT_ENABLES_PRIMARY;
  localparam logic [7:0] SE = irq_unit_pkg::IDX_EVENT_ENABLES_SECONDARY;
  logic        clock;
  logic        sys_rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [18:0] ev;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        pin_out;
  logic        pin_oe;
  logic        level;
  logic        pin_seen;
  logic        hresp;
  int          error_cnt;
  int          n_compared;

  reader_interrupt_request_unit u_reader_interrupt_request_unit (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .upper_level_live_status(ev[0]),
    .lower_level_live_status(ev[1]), .command_self_end(ev[2]),
    .command_unknown_start(ev[3]), .command_host_idle_start(ev[4]),
    .transmit_last_bit_sent(ev[5]), .receive_stream_end(ev[6]),
    .buffer_write_fault(ev[7]), .buffer_overflow_fault(ev[8]),
    .protocol_fault(ev[9]), .empty_send_fault(ev[10]),
    .integrity_fault(ev[11]), .frame_start_detect(ev[12]),
    .card_detect_event(ev[13]), .timer_underflow(ev[18:14]),
    .command_force_idle(), .request_pin_out(pin_out),
    .request_pin_oe(pin_oe), .request_level(level));
  host_pin_model u_host_pin_model (.request_pin_out(pin_out),
    .request_pin_oe(pin_oe), .pin_seen(pin_seen));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        final_report();
      end
      @(posedge clock);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= irq_unit_pkg::HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, idx, 32'h0, q);
    chk(q, e);
  endtask
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge clock);
    ev[b] <= 1'b0;
    @(posedge clock);
  endtask
  task automatic pins(input logic [3:0] e);
    repeat (3) @(posedge clock);
    chk({28'h0, pin_oe, pin_out, level, pin_seen}, {28'h0, e});
  endtask
  function automatic logic [31:0] exp_flag(input int i);
    case (i)
      0: exp_flag = 32'h40;
      1: exp_flag = 32'h20;
      2, 3: exp_flag = 32'h10;
      4: exp_flag = 32'h00;
      5: exp_flag = 32'h08;
      6: exp_flag = 32'h04;
      12: exp_flag = 32'h01;
      13: exp_flag = 32'h20;
      default: exp_flag = (i > 13) ? 32'h1 << (i - 14) : 32'h02;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset();
    rd(PF, 32'h0);
    rd(SF, 32'h0);
    rd(PE, 32'h0);
    rd(SE, 32'h0);
    chk({31'h0, hresp}, {31'h0, irq_unit_pkg::HRESP_OKAY});
    wr(8'h0a, 32'hff);
    rd(8'h0a, 32'h0);
    pins(4'b1000);
  endtask
  task automatic test_modes();
    wr(PF, 32'hff);
    rd(PF, 32'h7f);
    wr(PF, 32'h55);
    rd(PF, 32'h2a);
    wr(PF, 32'h7f);
    rd(PF, 32'h00);
    wr(SF, 32'ha1);
    rd(SF, 32'h21);
    wr(SF, 32'h01);
    rd(SF, 32'h20);
    wr(SF, 32'h7f);
    rd(SF, 32'h00);
  endtask
  task automatic test_events();
    for (int i = 0; i < 19; i++) begin
      ev[i] <= 1'b1;
      @(posedge clock);
      ev[i] <= 1'b0;
      rd(i > 12 ? SF : PF, exp_flag(i));
      wr(PF, 32'h7f);
      wr(SF, 32'h7f);
    end
  endtask
  task automatic test_pin();
    wr(PE, 32'h04);
    pulse(5);
    rd(SF, 32'h00);
    pulse(6);
    rd(SF, 32'h40);
    pins(4'b1000);
    wr(SE, 32'hc0);
    pins(4'b1111);
    wr(PE, 32'h84);
    pins(4'b1000);
    wr(SE, 32'h40);
    wr(PF, 32'h7f);
    wr(SF, 32'h7f);
    pins(4'b0011);
    wr(SE, 32'h41);
    pulse(14);
    rd(SF, 32'h41);
    pins(4'b1000);
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ev = 19'h0;
    error_cnt = 0;
    n_compared = 0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    test_reset();
    test_modes();
    test_events();
    test_pin();
    final_report();
  end
endmodule
